// ---- mtrl_pkg.sv ----
// Package with register indices, field positions, type codes and reset values for the range lookup block.
package mtrl_pkg;

  // Register indices on the model-specific register port.
  localparam logic [4:0] IDX_FIX64K_00000 = 5'h00;
  localparam logic [4:0] IDX_FIX16K_80000 = 5'h01;
  localparam logic [4:0] IDX_FIX16K_A0000 = 5'h02;
  localparam logic [4:0] IDX_FIX4K_C0000  = 5'h03;
  localparam logic [4:0] IDX_FIX4K_LAST   = 5'h0a;
  localparam logic [4:0] IDX_VAR_FIRST    = 5'h0b;
  localparam logic [4:0] IDX_VAR_LAST     = 5'h1a;
  localparam logic [4:0] IDX_DEFAULT_TYPE = 5'h1b;
  localparam int         NUM_FIXED        = 11;
  localparam int         NUM_VAR          = 8;

  // Field positions.
  localparam int TYPE_MSB     = 7;
  localparam int ADDR_MSB     = 51;
  localparam int ADDR_LSB     = 12;
  localparam int VALID_BIT    = 11;
  localparam int FIXED_EN_BIT = 10;
  localparam int GLOBAL_EN_BIT = 11;
  localparam int RD_MEM_BIT   = 4;
  localparam int WR_MEM_BIT   = 3;

  // Fixed-range address decode.
  localparam logic [51:0] ONE_MBYTE     = 52'h0_0000_0010_0000;
  localparam logic [51:0] SPLIT_16K     = 52'h0_0000_0008_0000;
  localparam logic [51:0] SPLIT_4K      = 52'h0_0000_000c_0000;

  // Type codes.
  localparam logic [7:0] UNCACHEABLE_TYPE  = 8'h00;
  localparam logic [7:0] WRITE_COMBINE     = 8'h01;
  localparam logic [7:0] WRITETHROUGH_TYPE = 8'h04;
  localparam logic [7:0] WRITE_PROTECT     = 8'h05;
  localparam logic [7:0] WRITEBACK_TYPE    = 8'h06;

  // Masks of writable bits.
  localparam logic [63:0] BASE_WR_MASK  = 64'h000f_ffff_ffff_f0ff;
  localparam logic [63:0] MASK_WR_MASK  = 64'h000f_ffff_ffff_f800;
  localparam logic [63:0] DEF_WR_MASK   = 64'h0000_0000_0000_0cff;
  localparam logic [63:0] REG_RESET     = 64'h0000_0000_0000_0000;

endpackage

// ---- mtrl_var_match.sv ----
// One variable range comparator: hit and type of a base/mask pair.
`timescale 1ns/1ps
`default_nettype none
module mtrl_var_match
(
  // Register contents.
  input  wire logic [63:0] base_word,
  input  wire logic [63:0] mask_word,
  // Address presented.
  input  wire logic [51:0] target_addr,
  // Results.
  output logic             hit,
  output logic [7:0]       range_type
);

  // A pair hits when valid and the masked base equals the masked address.
  always_comb
  begin
    hit        = mask_word[mtrl_pkg::VALID_BIT] &&
                 ((mask_word[51:12] & base_word[51:12]) ==
                  (mask_word[51:12] & target_addr[51:12]));
    range_type = base_word[7:0];
  end

endmodule
`default_nettype wire

// ---- mtrl_lookup.sv ----
// Memory-type range lookup with fixed, variable and default type registers.
//
// Functional notes
// - Fixed ranges apply only below 1 Mbyte.
// - Uncovered addresses get the default type.
// - Fixed register holds eight byte-wide slice types.
// - Lowest 512K split into eight 64K slices.
// - 80000-BFFFF split into sixteen 16K slices.
// - C0000-FFFFF split into sixty-four 4K slices.
// - Extended encodings accepted only in fixed fields.
// - Eight variable base/mask pairs exist.
// - Base bits 7:0 hold standard type.
// - Base bits 51:12 hold range base.
// - Mask bit 11 marks the pair valid.
// - Mask bits 51:12 hold range mask.
// - Hit when masked base equals masked address.
// - Registers read and write without read effects.
// - Fewer physical address bits may be implemented.
// - Default type field rejects extended encodings.
// - Bit 10 enables fixed ranges under global.
// - Bit 11 clear forces uncacheable everywhere.
// - Global enable leaves memory-route bits unchanged.
// - All registers are 64-bit model registers.
// - Type codes 00,01,04,05,06; standard bits 7:3 zero.
// - Fixed range beats variable range.
// - Variable overlap: same, else UC, WT+WB gives WT.
`timescale 1ns/1ps
`default_nettype none
module mtrl_lookup
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Model-specific register port.
  input  wire logic        reg_read,
  input  wire logic        reg_write,
  input  wire logic [4:0]  reg_index,
  input  wire logic [63:0] reg_wdata,
  output logic [63:0]      reg_rdata,
  output logic             reg_ack,
  output logic             reg_error,
  // Address lookup port.
  input  wire logic        lookup_valid,
  input  wire logic [51:0] lookup_addr,
  output logic             result_valid,
  output logic [7:0]       result_type,
  output logic             result_read_to_memory,
  output logic             result_write_to_memory
);

  // Whole state of the block in one packed struct.
  typedef struct packed {
    logic [10:0][63:0] fixed_regs;   // Fixed-range type registers.
    logic [15:0][63:0] var_regs;     // Base/mask pairs, base at even index.
    logic [63:0]       def_reg;      // Default type and enables.
    logic [63:0]       rdata;        // Read data latch.
    logic              ack;          // Access acknowledge.
    logic              err;          // Access to unknown index or bad value.
    logic              rvalid;       // Lookup result valid.
    logic [7:0]        rtype;        // Lookup result type.
    logic              rd_mem;       // Read-to-memory flag of result.
    logic              wr_mem;       // Write-to-memory flag of result.
  } mtrl_state_s;

  mtrl_state_s state_reg;   // Registered state.
  mtrl_state_s state_next;  // Next state.

  // Comparator outputs.
  logic [7:0]       var_hit;
  logic [7:0][7:0]  var_type;

  // One comparator per variable pair.
  genvar gi;
  generate
    for (gi = 0; gi < mtrl_pkg::NUM_VAR; gi++)
    begin : g_var
      mtrl_var_match u_match
      (
        .base_word   (state_reg.var_regs[2*gi]),
        .mask_word   (state_reg.var_regs[2*gi+1]),
        .target_addr (lookup_addr),
        .hit         (var_hit[gi]),
        .range_type  (var_type[gi])
      );
    end
  endgenerate

  // A standard encoding has bits 7:3 clear and a defined low code.
  function automatic logic std_type_ok(input logic [7:0] t);
    logic ok;
    ok = (t == mtrl_pkg::UNCACHEABLE_TYPE) || (t == mtrl_pkg::WRITE_COMBINE) ||
         (t == mtrl_pkg::WRITETHROUGH_TYPE) || (t == mtrl_pkg::WRITE_PROTECT) ||
         (t == mtrl_pkg::WRITEBACK_TYPE);
    return ok;
  endfunction

  // An extended encoding may also carry the two memory-route bits.
  function automatic logic ext_type_ok(input logic [7:0] t);
    logic ok;
    ok = (t[7:5] == 3'h0) && std_type_ok({5'h00, t[2:0]});
    return ok;
  endfunction

  // Fixed register checks all eight slice fields.
  function automatic logic fixed_word_ok(input logic [63:0] w);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      ok = ok && ext_type_ok(w[8*k +: 8]);
    end
    return ok;
  endfunction

  // Lookup scratch values.
  logic [3:0]  fix_reg_sel;   // Which fixed register covers the address.
  logic [2:0]  fix_slot;      // Which byte of it.
  logic [7:0]  fix_field;     // Selected fixed slice field.
  logic        any_hit;       // Some variable pair hit.
  logic        all_same;      // All hits agree.
  logic        any_uc;        // Some hit is uncacheable.
  logic        only_wt_wb;    // Hits are only writethrough and writeback.
  logic [7:0]  first_type;    // Type of the lowest hitting pair.
  logic [7:0]  var_result;    // Resolved variable type.

  // Fixed slice select from address bits below 1 Mbyte.
  always_comb
  begin
    if (lookup_addr < mtrl_pkg::SPLIT_16K)
    begin
      fix_reg_sel = 4'h0;
      fix_slot    = lookup_addr[18:16];
    end
    else if (lookup_addr < mtrl_pkg::SPLIT_4K)
    begin
      fix_reg_sel = {3'h0, lookup_addr[17]} + 4'h1;
      fix_slot    = lookup_addr[16:14];
    end
    else
    begin
      fix_reg_sel = {1'b0, lookup_addr[17:15]} + 4'h3;
      fix_slot    = lookup_addr[14:12];
    end
    fix_field = state_reg.fixed_regs[fix_reg_sel][{fix_slot, 3'h0} +: 8];
  end

  // Variable overlap resolution.
  always_comb
  begin
    any_hit    = |var_hit;
    first_type = mtrl_pkg::UNCACHEABLE_TYPE;
    for (int k = mtrl_pkg::NUM_VAR - 1; k >= 0; k--)
    begin
      if (var_hit[k])
      begin
        first_type = var_type[k];
      end
    end
    all_same   = 1'b1;
    any_uc     = 1'b0;
    only_wt_wb = 1'b1;
    for (int k = 0; k < mtrl_pkg::NUM_VAR; k++)
    begin
      if (var_hit[k])
      begin
        all_same   = all_same && (var_type[k] == first_type);
        any_uc     = any_uc || (var_type[k] == mtrl_pkg::UNCACHEABLE_TYPE);
        only_wt_wb = only_wt_wb && ((var_type[k] == mtrl_pkg::WRITETHROUGH_TYPE) ||
                                    (var_type[k] == mtrl_pkg::WRITEBACK_TYPE));
      end
    end
    // Identical first, then uncacheable, then writethrough; others undefined, taken as uncacheable.
    if (all_same)
    begin
      var_result = first_type;
    end
    else if (any_uc)
    begin
      var_result = mtrl_pkg::UNCACHEABLE_TYPE;
    end
    else if (only_wt_wb)
    begin
      var_result = mtrl_pkg::WRITETHROUGH_TYPE;
    end
    else
    begin
      var_result = mtrl_pkg::UNCACHEABLE_TYPE;
    end
  end

  // Next-state logic: register access and lookup result.
  always_comb
  begin
    logic global_en;
    logic fixed_en;
    logic in_fixed;
    int   vi;
    global_en  = state_reg.def_reg[mtrl_pkg::GLOBAL_EN_BIT];
    fixed_en   = state_reg.def_reg[mtrl_pkg::FIXED_EN_BIT];
    in_fixed   = lookup_addr < mtrl_pkg::ONE_MBYTE;
    vi         = 32'(reg_index) - 32'(mtrl_pkg::IDX_VAR_FIRST);
    state_next = state_reg;
    state_next.ack = 1'b0;
    state_next.err = 1'b0;

    // Register write: a field with a bad encoding is refused whole.
    if (reg_write)
    begin
      state_next.ack = 1'b1;
      if (reg_index <= mtrl_pkg::IDX_FIX4K_LAST)
      begin
        if (fixed_word_ok(reg_wdata))
        begin
          state_next.fixed_regs[reg_index[3:0]] = reg_wdata;
        end
        else
        begin
          state_next.err = 1'b1;
        end
      end
      else if (reg_index <= mtrl_pkg::IDX_VAR_LAST)
      begin
        if (vi[0])
        begin
          state_next.var_regs[vi[3:0]] = reg_wdata & mtrl_pkg::MASK_WR_MASK;
        end
        else if (std_type_ok(reg_wdata[7:0]))
        begin
          state_next.var_regs[vi[3:0]] = reg_wdata & mtrl_pkg::BASE_WR_MASK;
        end
        else
        begin
          state_next.err = 1'b1;
        end
      end
      else if (reg_index == mtrl_pkg::IDX_DEFAULT_TYPE)
      begin
        if (std_type_ok(reg_wdata[7:0]))
        begin
          state_next.def_reg = reg_wdata & mtrl_pkg::DEF_WR_MASK;
        end
        else
        begin
          state_next.err = 1'b1;
        end
      end
      else
      begin
        state_next.err = 1'b1;
      end
    end
    // Register read has no side effect beyond the returned word.
    else if (reg_read)
    begin
      state_next.ack = 1'b1;
      if (reg_index <= mtrl_pkg::IDX_FIX4K_LAST)
      begin
        state_next.rdata = state_reg.fixed_regs[reg_index[3:0]];
      end
      else if (reg_index <= mtrl_pkg::IDX_VAR_LAST)
      begin
        state_next.rdata = state_reg.var_regs[vi[3:0]];
      end
      else if (reg_index == mtrl_pkg::IDX_DEFAULT_TYPE)
      begin
        state_next.rdata = state_reg.def_reg;
      end
      else
      begin
        state_next.rdata = mtrl_pkg::REG_RESET;
        state_next.err   = 1'b1;
      end
    end

    // Lookup result, one cycle after presentation.
    state_next.rvalid = lookup_valid;
    if (lookup_valid)
    begin
      // Memory-route bits follow the fixed field whatever the global enable.
      state_next.rd_mem = in_fixed && fixed_en && fix_field[mtrl_pkg::RD_MEM_BIT];
      state_next.wr_mem = in_fixed && fixed_en && fix_field[mtrl_pkg::WR_MEM_BIT];
      if (!global_en)
      begin
        state_next.rtype = mtrl_pkg::UNCACHEABLE_TYPE;
      end
      else if (in_fixed && fixed_en)
      begin
        state_next.rtype = {5'h00, fix_field[2:0]};
      end
      else if (any_hit)
      begin
        state_next.rtype = var_result;
      end
      else
      begin
        state_next.rtype = state_reg.def_reg[mtrl_pkg::TYPE_MSB:0];
      end
    end
  end

  // State register.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs from flip-flops.
  assign reg_rdata              = state_reg.rdata;
  assign reg_ack                = state_reg.ack;
  assign reg_error              = state_reg.err;
  assign result_valid           = state_reg.rvalid;
  assign result_type            = state_reg.rtype;
  assign result_read_to_memory  = state_reg.rd_mem;
  assign result_write_to_memory = state_reg.wr_mem;

endmodule
`default_nettype wire

// ---- mtrl_lookup_sva.sv ----
// Port assertions for the range lookup block.
`timescale 1ns/1ps
`default_nettype none
module mtrl_lookup_chk
(
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        reset,
  // Register port.
  input wire logic        reg_read,
  input wire logic        reg_write,
  input wire logic [4:0]  reg_index,
  input wire logic [63:0] reg_wdata,
  input wire logic        reg_ack,
  input wire logic        reg_error,
  // Lookup port.
  input wire logic        lookup_valid,
  input wire logic [51:0] lookup_addr,
  input wire logic        result_valid,
  input wire logic [7:0]  result_type,
  input wire logic        result_read_to_memory,
  input wire logic        result_write_to_memory
);
  // All checks use the block clock and stop during reset.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Base registers sit at the odd indices of the variable block.
  logic base_sel;
  assign base_sel = reg_index >= 5'h0b && reg_index <= 5'h1a && reg_index[0];
  // A request and the answer that follows it.
  sequence s_access; reg_read || reg_write; endsequence
  sequence s_answer; reg_ack; endsequence
  property p_ack; s_access |=> s_answer; endproperty
  a_ack: assert property (p_ack) else $error("access not answered");
  property p_quiet; !(reg_read || reg_write) |=> !reg_ack && !reg_error; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without access");
  property p_unmapped; s_access ##0 (reg_index > 5'h1b) |=> reg_error; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped index accepted");
  property p_read_clean; reg_read && !reg_write && reg_index <= 5'h1b |=> reg_ack && !reg_error; endproperty
  a_read_clean: assert property (p_read_clean) else $error("read refused");
  property p_base_std; reg_write && base_sel && reg_wdata[7:3] != 5'h00 |=> reg_error; endproperty
  a_base_std: assert property (p_base_std) else $error("extended base type taken");
  property p_def_std; reg_write && reg_index == 5'h1b && reg_wdata[7:3] != 5'h00 |=> reg_error; endproperty
  a_def_std: assert property (p_def_std) else $error("extended default type taken");
  property p_result; lookup_valid |=> result_valid; endproperty
  a_result: assert property (p_result) else $error("lookup not answered");
  property p_hold; !lookup_valid |=> !result_valid && $stable(result_type); endproperty
  a_hold: assert property (p_hold) else $error("result changed without lookup");
  property p_high; lookup_valid && lookup_addr >= 52'h0_0000_0010_0000 |=> !result_read_to_memory
    && !result_write_to_memory; endproperty
  a_high: assert property (p_high) else $error("route flag above fixed area");
  property p_std; result_valid |-> result_type[7:3] == 5'h00; endproperty
  a_std: assert property (p_std) else $error("result type not standard");
endmodule
`default_nettype wire

// ---- mtrl_cpu_path.sv ----
// Model of the processor access path that presents physical addresses.
`timescale 1ns/1ps
`default_nettype none
module mtrl_cpu_path
(
  // Clock.
  input wire logic    sys_clk,
  // Address handed to the lookup.
  output logic        lookup_valid,
  output logic [51:0] lookup_addr
);
  // Idle until the first request.
  initial
  begin
    lookup_valid = 1'b0;
    lookup_addr  = 52'h0;
  end
  // Presents one address for one cycle; idle address is inverted so it never looks stale.
  task automatic present(input logic [51:0] addr);
    @(posedge sys_clk);
    #1;
    lookup_valid = 1'b1;
    lookup_addr  = addr;
    @(posedge sys_clk);
    #1;
    lookup_valid = 1'b0;
    lookup_addr  = ~addr;
  endtask
endmodule
`default_nettype wire

// ---- mtrl_lookup_tb.sv ----
// Self-checking testbench for the range lookup block.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", what, exp, got); end end
module testbench;
  logic        sys_clk;
  logic        reset;
  logic        reg_read;
  logic        reg_write;
  logic [4:0]  reg_index;
  logic [63:0] reg_wdata;
  logic [63:0] reg_rdata;
  logic        reg_ack;
  logic        reg_error;
  logic        lookup_valid;
  logic [51:0] lookup_addr;
  logic        result_valid;
  logic [7:0]  result_type;
  logic        result_read_to_memory;
  logic        result_write_to_memory;
  logic [65:0] reg_notes[$];  // Check-data flag, error, data.
  logic [9:0]  look_notes[$]; // Read route, write route, type.
  logic [65:0] rn;
  logic [9:0]  ln;
  logic [31:0] seed;
  logic [63:0] pat;
  logic [63:0] word;
  int          miscompares;
  int          tests_run;
  mtrl_lookup i_dut (.sys_clk(sys_clk), .reset(reset), .reg_read(reg_read), .reg_write(reg_write),
    .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .reg_error(reg_error), .lookup_valid(lookup_valid), .lookup_addr(lookup_addr),
    .result_valid(result_valid), .result_type(result_type),
    .result_read_to_memory(result_read_to_memory), .result_write_to_memory(result_write_to_memory));
  mtrl_cpu_path i_cpu (.sys_clk(sys_clk), .lookup_valid(lookup_valid), .lookup_addr(lookup_addr));
  // Free-running 25 MHz clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Pseudo-random source for in-range offsets.
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Address of slice i of fixed register r; odd slices probe an address 0xfff above their start.
  function automatic logic [51:0] slice_addr(input int r, input int i);
    logic [51:0] odd;
    odd = 52'(i % 2) * 52'hfff;
    if (r == 0)
      return 52'(i) * 52'h1_0000 + odd;
    if (r < 3)
      return 52'h8_0000 + 52'(r - 1) * 52'h2_0000 + 52'(i) * 52'h4000 + odd;
    return 52'hc_0000 + 52'(r - 3) * 52'h8000 + 52'(i) * 52'h1000 + odd;
  endfunction
  // One register access, held for one cycle after an edge.
  task automatic access(input logic w, input logic [4:0] idx, input logic [63:0] d, input logic [65:0] note);
    reg_notes.push_back(note);
    @(posedge sys_clk);
    #1;
    reg_write = w;
    reg_read  = ~w;
    reg_index = idx;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_write = 1'b0;
    reg_read  = 1'b0;
  endtask
  task automatic wr(input logic [4:0] idx, input logic [63:0] d, input logic err);
    access(1'b1, idx, d, {1'b0, err, 64'h0});
  endtask
  task automatic rd(input logic [4:0] idx, input logic [63:0] exp, input logic err);
    access(1'b0, idx, 64'h0, {1'b1, err, exp});
  endtask
  task automatic look(input logic [51:0] a, input logic [9:0] exp);
    look_notes.push_back(exp);
    i_cpu.present(a);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Takes the oldest note whenever an answer shows and compares it.
  always @(posedge sys_clk)
  begin
    #2;
    if (reg_ack === 1'b1)
    begin
      rn = reg_notes.size() > 0 ? reg_notes.pop_front() : 'x;
      `CHECK("reg_error", rn[64], reg_error)
      if (rn[65] !== 1'b0)
        `CHECK("reg_rdata", rn[63:0], reg_rdata)
    end
    if (result_valid === 1'b1)
    begin
      ln = look_notes.size() > 0 ? look_notes.pop_front() : 'x;
      `CHECK("result", ln, {result_read_to_memory, result_write_to_memory, result_type})
    end
  end
  // Watchdog against a hang.
  initial
  begin
    repeat (50000) @(posedge sys_clk);
    miscompares++;
    wrap_up();
  end
  initial
  begin
    miscompares = 0;
    tests_run = 0;
    seed = 32'hd7ea110e;
    reset = 1'b1;
    reg_read = 1'b0;
    reg_write = 1'b0;
    reg_index = 5'h00;
    reg_wdata = 64'h0;
    repeat (10) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    // Cleared out of reset; typing stays off while the global enable is clear.
    rd(5'h1b, 64'h0, 1'b0);
    rd(5'h1c, 64'h0, 1'b1);
    wr(5'h1b, 64'h006, 1'b0);
    look(52'h1234_5000, 10'h000);
    wr(5'h1b, 64'h002, 1'b1);
    wr(5'h1b, 64'h018, 1'b1);
    wr(5'h1b, 64'hf000_0000_0000_fc06, 1'b0);
    rd(5'h1b, 64'hc06, 1'b0);
    // All 88 slices, each register rotated so a byte swap shows.
    pat = 64'h0605_0401_0006_0504;
    for (int r = 0; r < 11; r++)
    begin
      word = 64'({pat, pat} >> (8 * (r % 8)));
      wr(5'(r), word, 1'b0);
      for (int i = 0; i < 8; i++)
        look(slice_addr(r, i), {2'b00, word[8 * i +: 8]});
    end
    rd(5'h00, pat, 1'b0);
    // Extended codes route reads and writes, also with typing off.
    wr(5'h03, 64'h0d16, 1'b0);
    look(52'hc_0000, {2'b10, 8'h06});
    look(52'hc_1fff, {2'b01, 8'h05});
    // A fixed field with a reserved high bit is refused and the register keeps its word.
    wr(5'h03, 64'h2716, 1'b1);
    rd(5'h03, 64'h0d16, 1'b0);
    wr(5'h1b, 64'h406, 1'b0);
    look(52'hc_0000, {2'b10, 8'h00});
    // Variable range of 32 Mbytes at 0x2000000, writeback.
    wr(5'h1b, 64'hc05, 1'b0);
    wr(5'h0b, 64'h016, 1'b1);
    wr(5'h0b, 64'h200_0006, 1'b0);
    wr(5'h0c, 64'hf_ffff_fe00_0800, 1'b0);
    rd(5'h0c, 64'hf_ffff_fe00_0800, 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      seed = xorshift(seed);
      look(52'h200_0000 + 52'(seed[24:0]), 10'h006);
    end
    look(52'h1ff_ffff, 10'h005);
    look(52'h400_0000, 10'h005);
    // Overlaps: writethrough with writeback, then uncacheable once valid.
    wr(5'h0d, 64'h200_0004, 1'b0);
    wr(5'h0e, 64'hf_ffff_ff00_0800, 1'b0);
    wr(5'h0f, 64'h200_0000, 1'b0);
    wr(5'h10, 64'hf_ffff_ff00_0000, 1'b0);
    look(52'h200_0100, 10'h004);
    look(52'h300_0000, 10'h006);
    wr(5'h10, 64'hf_ffff_ff00_0800, 1'b0);
    look(52'h200_0100, 10'h000);
    // A variable range over the first Mbyte loses to the fixed ranges.
    wr(5'h11, 64'h006, 1'b0);
    wr(5'h12, 64'hf_ffff_fff0_0800, 1'b0);
    look(52'h3_0000, 10'h000);
    look(52'h10_0000, 10'h005);
    wr(5'h1b, 64'h805, 1'b0);
    look(52'h3_0000, 10'h006);
    // Reserved bits read zero; the last pair covers the top page.
    wr(5'h1a, 64'hffff_ffff_ffff_ffff, 1'b0);
    rd(5'h1a, 64'h000f_ffff_ffff_f800, 1'b0);
    wr(5'h19, 64'hffff_ffff_ffff_ff06, 1'b0);
    rd(5'h19, 64'h000f_ffff_ffff_f006, 1'b0);
    look(52'hf_ffff_ffff_f000, 10'h006);
    // A reset in mid-run clears every register and turns typing off again.
    @(posedge sys_clk);
    #1;
    reset = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    rd(5'h1a, 64'h0, 1'b0);
    look(52'h3_0000, 10'h000);
    for (int i = 0; i < 10 && reg_notes.size() + look_notes.size() > 0; i++)
      @(posedge sys_clk);
    if (reg_notes.size() + look_notes.size() > 0)
      miscompares++;
    wrap_up();
  end
endmodule
bind mtrl_lookup mtrl_lookup_chk i_chk (.sys_clk(sys_clk), .reset(reset), .reg_read(reg_read),
  .reg_write(reg_write), .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
  .reg_error(reg_error), .lookup_valid(lookup_valid), .lookup_addr(lookup_addr),
  .result_valid(result_valid), .result_type(result_type),
  .result_read_to_memory(result_read_to_memory), .result_write_to_memory(result_write_to_memory));
`default_nettype wire
